// >>> verilog/status_params.svh
// Offsets, bit positions and timing constants of the raw status block
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

`define ADDR_W 16
`define DATA_W 16
`define WORD_ZERO 16'h0000

`define ADDR_RAW_TWO 16'h0D21
`define ADDR_RAW_THREE 16'h0D22
`define ADDR_RAW_FOUR 16'h0D23
`define ADDR_RAW_FIVE 16'h0D24
`define ADDR_CLK_CTRL 16'h0100
`define ADDR_PHONE_CTRL 16'h0101

`define B2_SYS_UNDER 1
`define B2_ASYNC_UNDER 0
`define B3_CTRL_ERR 12
`define B3_MIX_DROP 11
`define B3_ASYNC_OFF 10
`define B3_SYS_OFF 9
`define B3_ISO1 8
`define B3_ISO2 7
`define B3_ISO3 6
`define B3_RIGHT_DONE 1
`define B3_LEFT_DONE 0
`define B4_BOOT 8
`define B4_ASRC_ERR 3
`define B4_LOOP2_OK 1
`define B4_LOOP1_OK 0
`define B5_PWM_OVER 13

`define CC_SYS_ENA 0
`define CC_ASYNC_ENA 1
`define PC_LEFT_ENA 0
`define PC_RIGHT_ENA 1

`define SRC_W 19
`define SRC_SYS_UNDER 0
`define SRC_ASYNC_UNDER 1
`define SRC_CTRL_FAULT 2
`define SRC_MIX_DROP 3
`define SRC_ISO_LO 4
`define SRC_ISO_HI 6
`define SRC_ASRC_ERR 7
`define SRC_LOOP_LO 8
`define SRC_LOOP_HI 9
`define SRC_PWM_OVER 10
`define SRC_OTHER_LO 11
`define SRC_OTHER_HI 18
`define OTHER_OVER_W 8

`define CLK_PERIOD_NS 20
`define BOOT_TIME_NS 2000
`define PHONE_SEQ_TIME_NS 1000
`define CLK_OFF_TIME_NS 200
`define BOOT_CYCLES ((`BOOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHONE_SEQ_CYCLES \
  ((`PHONE_SEQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_OFF_CYCLES \
  ((`CLK_OFF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_CNT_W 8
// Age after reset at which boot reads complete: start, timer, done register
`define BOOT_DONE_AGE (`BOOT_CYCLES + 2)

`endif

// >>> verilog/status_pkg.sv
// Types shared by the raw status block
package status_pkg;
  typedef enum logic [0:0] {
    BOOT_RUN = 1'b0,
    BOOT_IDLE = 1'b1
  } boot_state_t;
  typedef logic [15:0] word_t;
endpackage : status_pkg

// >>> verilog/seq_if.sv
// Start and completion pair between the block and one sequence timer
interface seq_if;
  logic start;
  logic done;
  modport owner (output start, input done);
  modport timer (input start, output done);
endinterface : seq_if

// >>> verilog/flag_sync.sv
// Two-stage synchroniser for a vector of independent level flags
module flag_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule : flag_sync

// >>> verilog/seq_timer.sv
// Countdown timer: a start pulse loads it, done pulses when it runs out
`include "status_params.svh"
module seq_timer #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  seq_if.timer link
);
  localparam logic [`SEQ_CNT_W-1:0] LOAD = `SEQ_CNT_W'(CYCLES);
  localparam logic [`SEQ_CNT_W-1:0] LAST = `SEQ_CNT_W'(1);
  logic [`SEQ_CNT_W-1:0] count;
  logic [`SEQ_CNT_W-1:0] next_count;
  logic doneReg;
  logic next_doneReg;

  // A restart while running reloads, so only the latest start completes
  always_comb begin
    next_count = count;
    next_doneReg = 1'b0;
    if (link.start) begin
      next_count = LOAD;
    end else if (count != '0) begin
      next_count = count - LAST;
      next_doneReg = (count == LAST);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      doneReg <= 1'b0;
    end else begin
      count <= next_count;
      doneReg <= next_doneReg;
    end
  end

  assign link.done = doneReg;

  property p_done_at_end;
    @(posedge mclk) disable iff (!rst_n)
      doneReg |-> $past(count) == LAST && !$past(link.start);
  endproperty
  a_done_at_end: assert property (p_done_at_end)
    else $error("timer done without reaching its last count");
endmodule : seq_timer

// >>> verilog/raw_status_flags.sv
// Raw status words of the audio hub with their control and sequencing
//
// Local design decision: the strobed register port.
`include "status_params.svh"
module raw_status_flags (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`DATA_W-1:0] rdata,
  input wire logic sysUnderclock,
  input wire logic asyncUnderclock,
  input wire logic controlFault,
  input wire logic mixerSampleDrop,
  input wire logic [2:0] isoConfigError,
  input wire logic asyncConverterConfigError,
  input wire logic [1:0] loopClockGood,
  input wire logic pulseWidthOverclock,
  input wire logic [`OTHER_OVER_W-1:0] otherOverclock,
  output logic systemClockEnable,
  output logic asyncClockEnable,
  output logic leftPhoneEnable,
  output logic rightPhoneEnable,
  output logic bootComplete,
  output logic summaryOverclock
);
  localparam int PHONE_WAIT_MAX = 60;
  logic [`SRC_W-1:0] rawSrc, src;
  status_pkg::word_t wordTwo, wordThree, wordFour, wordFive, readMux;
  status_pkg::boot_state_t bootState, next_bootState;
  logic bootStarted, sysOff, asyncOff, leftDone, rightDone, ctrlErr;
  logic next_bootStarted, next_systemClockEnable, next_asyncClockEnable;
  logic next_leftPhoneEnable, next_rightPhoneEnable, next_sysOff;
  logic next_asyncOff, next_leftDone, next_rightDone, next_ctrlErr;
  logic next_summaryOverclock;
  logic [`DATA_W-1:0] next_rdata;
  logic writeClk, writePhone, writeRaw, writeBad;
  logic [7:0] bootAge;
  seq_if bootSeq ();
  seq_if sysOffSeq ();
  seq_if asyncOffSeq ();
  seq_if leftSeq ();
  seq_if rightSeq ();

  assign rawSrc = {otherOverclock, pulseWidthOverclock, loopClockGood,
                   asyncConverterConfigError, isoConfigError,
                   mixerSampleDrop, controlFault, asyncUnderclock,
                   sysUnderclock};

  // Sources live in other clock domains of the hub
  flag_sync #(.WIDTH(`SRC_W)) srcSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(rawSrc),
    .dout(src)
  );

  seq_timer #(.CYCLES(`BOOT_CYCLES)) bootTimer (
    .mclk(mclk), .rst_n(rst_n), .link(bootSeq.timer));
  seq_timer #(.CYCLES(`CLK_OFF_CYCLES)) sysOffTimer (
    .mclk(mclk), .rst_n(rst_n), .link(sysOffSeq.timer));
  seq_timer #(.CYCLES(`CLK_OFF_CYCLES)) asyncOffTimer (
    .mclk(mclk), .rst_n(rst_n), .link(asyncOffSeq.timer));
  seq_timer #(.CYCLES(`PHONE_SEQ_CYCLES)) leftTimer (
    .mclk(mclk), .rst_n(rst_n), .link(leftSeq.timer));
  seq_timer #(.CYCLES(`PHONE_SEQ_CYCLES)) rightTimer (
    .mclk(mclk), .rst_n(rst_n), .link(rightSeq.timer));

  // Control writes before boot completes are not honoured and count as errors
  assign writeClk = wr && addr == `ADDR_CLK_CTRL && bootComplete;
  assign writePhone = wr && addr == `ADDR_PHONE_CTRL && bootComplete;
  assign writeRaw = wr && (addr == `ADDR_RAW_TWO || addr == `ADDR_RAW_THREE
                    || addr == `ADDR_RAW_FOUR || addr == `ADDR_RAW_FIVE);
  assign writeBad = wr && !writeRaw && (!bootComplete
                    || (addr != `ADDR_CLK_CTRL && addr != `ADDR_PHONE_CTRL));

  assign bootSeq.start = !bootStarted;
  assign sysOffSeq.start = writeClk && systemClockEnable
                           && !wdata[`CC_SYS_ENA];
  assign asyncOffSeq.start = writeClk && asyncClockEnable
                             && !wdata[`CC_ASYNC_ENA];
  assign leftSeq.start = writePhone && !leftPhoneEnable
                         && wdata[`PC_LEFT_ENA];
  assign rightSeq.start = writePhone && !rightPhoneEnable
                          && wdata[`PC_RIGHT_ENA];

  always_comb begin
    wordTwo = `WORD_ZERO;
    wordTwo[`B2_SYS_UNDER] = src[`SRC_SYS_UNDER];
    wordTwo[`B2_ASYNC_UNDER] = src[`SRC_ASYNC_UNDER];
    wordThree = `WORD_ZERO;
    wordThree[`B3_CTRL_ERR] = ctrlErr;
    wordThree[`B3_MIX_DROP] = src[`SRC_MIX_DROP];
    wordThree[`B3_ASYNC_OFF] = asyncOff;
    wordThree[`B3_SYS_OFF] = sysOff;
    wordThree[`B3_ISO1] = src[`SRC_ISO_LO];
    wordThree[`B3_ISO2] = src[`SRC_ISO_LO+1];
    wordThree[`B3_ISO3] = src[`SRC_ISO_HI];
    wordThree[`B3_RIGHT_DONE] = rightDone;
    wordThree[`B3_LEFT_DONE] = leftDone;
    wordFour = `WORD_ZERO;
    wordFour[`B4_BOOT] = bootComplete;
    wordFour[`B4_ASRC_ERR] = src[`SRC_ASRC_ERR];
    wordFour[`B4_LOOP2_OK] = src[`SRC_LOOP_HI];
    wordFour[`B4_LOOP1_OK] = src[`SRC_LOOP_LO];
    wordFive = `WORD_ZERO;
    wordFive[`B5_PWM_OVER] = src[`SRC_PWM_OVER];
  end

  always_comb begin
    unique case (addr)
      `ADDR_RAW_TWO: readMux = wordTwo;
      `ADDR_RAW_THREE: readMux = wordThree;
      `ADDR_RAW_FOUR: readMux = wordFour;
      `ADDR_RAW_FIVE: readMux = wordFive;
      `ADDR_CLK_CTRL: begin
        readMux = `WORD_ZERO;
        readMux[`CC_SYS_ENA] = systemClockEnable;
        readMux[`CC_ASYNC_ENA] = asyncClockEnable;
      end
      `ADDR_PHONE_CTRL: begin
        readMux = `WORD_ZERO;
        readMux[`PC_LEFT_ENA] = leftPhoneEnable;
        readMux[`PC_RIGHT_ENA] = rightPhoneEnable;
      end
      default: readMux = `WORD_ZERO;
    endcase
  end

  always_comb begin
    next_bootStarted = 1'b1;
    next_bootState = bootState;
    if (bootState == status_pkg::BOOT_RUN && bootSeq.done) begin
      next_bootState = status_pkg::BOOT_IDLE;
    end
    next_systemClockEnable = systemClockEnable;
    next_asyncClockEnable = asyncClockEnable;
    next_leftPhoneEnable = leftPhoneEnable;
    next_rightPhoneEnable = rightPhoneEnable;
    // Status words ignore writes; only the control words take them
    if (writeClk) begin
      next_systemClockEnable = wdata[`CC_SYS_ENA];
      next_asyncClockEnable = wdata[`CC_ASYNC_ENA];
    end
    if (writePhone) begin
      next_leftPhoneEnable = wdata[`PC_LEFT_ENA];
      next_rightPhoneEnable = wdata[`PC_RIGHT_ENA];
    end
    // Off flag drops at once on re-enable; a stale timer is ignored
    next_sysOff = sysOff;
    if (next_systemClockEnable) begin
      next_sysOff = 1'b0;
    end else if (sysOffSeq.done) begin
      next_sysOff = 1'b1;
    end
    next_asyncOff = asyncOff;
    if (next_asyncClockEnable) begin
      next_asyncOff = 1'b0;
    end else if (asyncOffSeq.done) begin
      next_asyncOff = 1'b1;
    end
    next_leftDone = leftDone;
    if (!next_leftPhoneEnable || leftSeq.start) begin
      next_leftDone = 1'b0;
    end else if (leftSeq.done) begin
      next_leftDone = 1'b1;
    end
    next_rightDone = rightDone;
    if (!next_rightPhoneEnable || rightSeq.start) begin
      next_rightDone = 1'b0;
    end else if (rightSeq.done) begin
      next_rightDone = 1'b1;
    end
    // Sticky until word three is read; a new error in that cycle wins
    next_ctrlErr = ctrlErr;
    if (rd && addr == `ADDR_RAW_THREE) begin
      next_ctrlErr = 1'b0;
    end
    if (src[`SRC_CTRL_FAULT] || writeBad) begin
      next_ctrlErr = 1'b1;
    end
    next_summaryOverclock = src[`SRC_PWM_OVER]
                            || (|src[`SRC_OTHER_HI:`SRC_OTHER_LO]);
    next_rdata = rd ? readMux : `WORD_ZERO;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootStarted <= 1'b0;
      bootState <= status_pkg::BOOT_RUN;
      systemClockEnable <= 1'b0;
      asyncClockEnable <= 1'b0;
      leftPhoneEnable <= 1'b0;
      rightPhoneEnable <= 1'b0;
      sysOff <= 1'b0;
      asyncOff <= 1'b0;
      leftDone <= 1'b0;
      rightDone <= 1'b0;
      ctrlErr <= 1'b0;
      summaryOverclock <= 1'b0;
      rdata <= `WORD_ZERO;
    end else begin
      bootStarted <= next_bootStarted;
      bootState <= next_bootState;
      systemClockEnable <= next_systemClockEnable;
      asyncClockEnable <= next_asyncClockEnable;
      leftPhoneEnable <= next_leftPhoneEnable;
      rightPhoneEnable <= next_rightPhoneEnable;
      sysOff <= next_sysOff;
      asyncOff <= next_asyncOff;
      leftDone <= next_leftDone;
      rightDone <= next_rightDone;
      ctrlErr <= next_ctrlErr;
      summaryOverclock <= next_summaryOverclock;
      rdata <= next_rdata;
    end
  end

  assign bootComplete = (bootState == status_pkg::BOOT_IDLE);

  // Cycles since reset release, saturating, for the boot check only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootAge <= 8'h00;
    end else if (bootAge != 8'hFF) begin
      bootAge <= bootAge + 8'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_read_two;
    rd && addr == `ADDR_RAW_TWO;
  endsequence
  sequence s_read_three;
    rd && addr == `ADDR_RAW_THREE;
  endsequence
  sequence s_read_four;
    rd && addr == `ADDR_RAW_FOUR;
  endsequence
  sequence s_sys_clear;
    writeClk && systemClockEnable && !wdata[`CC_SYS_ENA];
  endsequence
  sequence s_async_clear;
    writeClk && asyncClockEnable && !wdata[`CC_ASYNC_ENA];
  endsequence
  sequence s_left_start;
    writePhone && !leftPhoneEnable && wdata[`PC_LEFT_ENA];
  endsequence

  property p_sys_under;
    s_read_two |=> rdata[`B2_SYS_UNDER] == $past(sysUnderclock, 3);
  endproperty
  a_sys_under: assert property (p_sys_under)
    else $error("system underclock bit does not follow its source");
  property p_async_under;
    s_read_two |=> rdata[`B2_ASYNC_UNDER] == $past(asyncUnderclock, 3);
  endproperty
  a_async_under: assert property (p_async_under)
    else $error("async underclock bit does not follow its source");
  property p_ctrl_err;
    $past(controlFault, 3) |-> ctrlErr;
  endproperty
  a_ctrl_err: assert property (p_ctrl_err)
    else $error("control interface error not flagged");
  property p_mix_drop;
    s_read_three |=> rdata[`B3_MIX_DROP] == $past(mixerSampleDrop, 3);
  endproperty
  a_mix_drop: assert property (p_mix_drop)
    else $error("mixer drop bit does not follow its source");
  property p_async_off;
    s_async_clear ##1 (!writeClk [*8]) ##1 (!writeClk [*4]) |->
      asyncOff && !asyncClockEnable;
  endproperty
  a_async_off: assert property (p_async_off)
    else $error("async clock off flag not raised in time");
  property p_sys_off;
    s_sys_clear |=> (!sysOff [*8]) ##1 (!sysOff [*3]) ##1 sysOff;
  endproperty
  a_sys_off: assert property (p_sys_off)
    else $error("system clock off flag early or late");
  property p_iso_err;
    s_read_three |=> rdata[`B3_ISO1] == $past(isoConfigError[0], 3)
      && rdata[`B3_ISO3] == $past(isoConfigError[2], 3);
  endproperty
  a_iso_err: assert property (p_iso_err)
    else $error("converter config error bits do not follow sources");
  property p_left_done;
    s_left_start |=> (!leftDone && leftPhoneEnable) [*8]
      ##[1:PHONE_WAIT_MAX] leftDone;
  endproperty
  a_left_done: assert property (p_left_done)
    else $error("left phone enable sequence did not finish in time");
  property p_boot;
    (bootAge < 8'(`BOOT_DONE_AGE) |-> !bootComplete)
      and (bootAge >= 8'(`BOOT_DONE_AGE) |-> bootComplete);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot completion at the wrong time");
  property p_asrc_loop;
    s_read_four |=> rdata[`B4_ASRC_ERR] ==
      $past(asyncConverterConfigError, 3)
      && rdata[`B4_LOOP2_OK] == $past(loopClockGood[1], 3);
  endproperty
  a_asrc_loop: assert property (p_asrc_loop)
    else $error("converter error or loop clock bits wrong");
  property p_summary;
    summaryOverclock == ($past(pulseWidthOverclock, 3)
      || (|$past(otherOverclock, 3)));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary overclock flag does not match its sources");
  property p_read_only;
    writeRaw |=> $stable(systemClockEnable) && $stable(asyncClockEnable)
      && $stable(leftPhoneEnable) && $stable(rightPhoneEnable)
      && ($stable(ctrlErr) || $past(src[`SRC_CTRL_FAULT]));
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("write to a status word changed block state");
endmodule : raw_status_flags

// >>> testbench/host_model.sv
// Host processor model that reaches the status block over its register port
`include "status_params.svh"
module host_model (
  input wire logic mclk,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [`DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : write_reg

  // Read data stand only in the cycle after the strobe
  task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : read_reg

  // Bounded poll so a flag that never rises cannot hang the host
  task automatic poll_bit(input logic [15:0] a, input int b, output logic ok);
    logic [15:0] v;
    ok = 1'b0;
    for (int i = 0; i < 80 && !ok; i++) begin
      read_reg(a, v);
      ok = (v[b] === 1'b1);
    end
  endtask : poll_bit

  // No other write goes out until the off flag reads one or the 80-read poll gives up
  task automatic clock_write(input logic [15:0] d, input int b,
      output logic first, output logic ok);
    logic [15:0] v;
    write_reg(`ADDR_CLK_CTRL, d);
    read_reg(`ADDR_RAW_THREE, v);
    first = v[b];
    poll_bit(`ADDR_RAW_THREE, b, ok);
  endtask : clock_write
endmodule : host_model

// >>> testbench/test_interrupt_raw_status_flags.sv
// Self-checking bench of the raw status flag block
`include "status_params.svh"
module test_interrupt_raw_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [`SRC_W-1:0] src;
    logic [15:0] w2, w3, w4, w5;
    logic summ;
  } row_t;
  row_t rows [14] = '{
    '{19'h00000, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 1'b0},
    '{19'h00001, 16'h0002, 16'h0000, 16'h0100, 16'h0000, 1'b0},
    '{19'h00002, 16'h0001, 16'h0000, 16'h0100, 16'h0000, 1'b0},
    '{19'h00008, 16'h0000, 16'h0800, 16'h0100, 16'h0000, 1'b0},
    '{19'h00010, 16'h0000, 16'h0100, 16'h0100, 16'h0000, 1'b0},
    '{19'h00020, 16'h0000, 16'h0080, 16'h0100, 16'h0000, 1'b0},
    '{19'h00040, 16'h0000, 16'h0040, 16'h0100, 16'h0000, 1'b0},
    '{19'h00080, 16'h0000, 16'h0000, 16'h0108, 16'h0000, 1'b0},
    '{19'h00100, 16'h0000, 16'h0000, 16'h0101, 16'h0000, 1'b0},
    '{19'h00200, 16'h0000, 16'h0000, 16'h0102, 16'h0000, 1'b0},
    '{19'h00400, 16'h0000, 16'h0000, 16'h0100, 16'h2000, 1'b1},
    '{19'h40000, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 1'b1},
    '{19'h7FFFB, 16'h0003, 16'h09C0, 16'h010B, 16'h2000, 1'b1},
    '{19'h00000, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 1'b0}
  };
  logic mclk;
  logic rst_n;
  logic [`SRC_W-1:0] src;
  logic [15:0] addr, wdata, rdata, v;
  logic wr, rd, ok, first;
  logic sysEna, asyncEna, leftEna, rightEna, bootDone, summ;
  int badCount = 0;
  int compares = 0;
  int cycles = 0;

  host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  raw_status_flags uut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sysUnderclock(src[`SRC_SYS_UNDER]),
    .asyncUnderclock(src[`SRC_ASYNC_UNDER]),
    .controlFault(src[`SRC_CTRL_FAULT]),
    .mixerSampleDrop(src[`SRC_MIX_DROP]),
    .isoConfigError(src[`SRC_ISO_HI:`SRC_ISO_LO]),
    .asyncConverterConfigError(src[`SRC_ASRC_ERR]),
    .loopClockGood(src[`SRC_LOOP_HI:`SRC_LOOP_LO]),
    .pulseWidthOverclock(src[`SRC_PWM_OVER]),
    .otherOverclock(src[`SRC_OTHER_HI:`SRC_OTHER_LO]),
    .systemClockEnable(sysEna), .asyncClockEnable(asyncEna),
    .leftPhoneEnable(leftEna), .rightPhoneEnable(rightEna),
    .bootComplete(bootDone), .summaryOverclock(summ));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    if (badCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finishTest

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      badCount++;
      finishTest();
    end
  end

  task automatic boot_up();
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    check("boot flag", {15'h0000, bootDone}, 16'h0000);
    host.read_reg(`ADDR_RAW_FOUR, v);
    check("word four in boot", v, 16'h0000);
  endtask : boot_up

  task automatic read_check(input string name, input logic [15:0] a,
      input logic [15:0] exp);
    host.read_reg(a, v);
    check(name, v, exp);
  endtask : read_check

  initial begin
    rst_n = 1'b0;
    src = '0;
    repeat (12) @(posedge mclk);
    check("outputs in reset", {10'h000, sysEna, asyncEna, leftEna,
      rightEna, bootDone, summ}, 16'h0000);
    boot_up();
    // Early write breaks the host rule on purpose and must be refused
    host.write_reg(`ADDR_CLK_CTRL, 16'h0003);
    #1;
    check("early write", {14'h0000, asyncEna, sysEna}, 16'h0000);
    host.poll_bit(`ADDR_RAW_FOUR, `B4_BOOT, ok);
    check("boot done", {15'h0000, ok}, 16'h0001);
    read_check("error after early write", `ADDR_RAW_THREE, 16'h1000);
    read_check("error cleared", `ADDR_RAW_THREE, 16'h0000);
    foreach (rows[i]) begin
      @(posedge mclk);
      src <= rows[i].src;
      repeat (4) @(posedge mclk);
      read_check("word two", `ADDR_RAW_TWO, rows[i].w2);
      read_check("word three", `ADDR_RAW_THREE, rows[i].w3);
      read_check("word four", `ADDR_RAW_FOUR, rows[i].w4);
      read_check("word five", `ADDR_RAW_FIVE, rows[i].w5);
      check("summary", {15'h0000, summ}, {15'h0000, rows[i].summ});
    end
    host.write_reg(`ADDR_CLK_CTRL, 16'h0003);
    #1;
    check("clock enables", {14'h0000, asyncEna, sysEna}, 16'h0003);
    read_check("both clocks on", `ADDR_RAW_THREE, 16'h0000);
    host.clock_write(16'h0002, `B3_SYS_OFF, first, ok);
    check("system off busy", {15'h0000, first}, 16'h0000);
    check("system off flag", {14'h0000, ok, sysEna}, 16'h0002);
    host.write_reg(`ADDR_CLK_CTRL, 16'h0003);
    read_check("system back on", `ADDR_RAW_THREE, 16'h0000);
    host.clock_write(16'h0001, `B3_ASYNC_OFF, first, ok);
    check("async off busy", {15'h0000, first}, 16'h0000);
    check("async off flag", {14'h0000, ok, asyncEna}, 16'h0002);
    host.write_reg(`ADDR_CLK_CTRL, 16'h0003);
    read_check("async back on", `ADDR_RAW_THREE, 16'h0000);
    host.write_reg(`ADDR_PHONE_CTRL, 16'h0003);
    #1;
    check("phone enables", {14'h0000, rightEna, leftEna}, 16'h0003);
    read_check("phone busy", `ADDR_RAW_THREE, 16'h0000);
    host.poll_bit(`ADDR_RAW_THREE, `B3_LEFT_DONE, ok);
    check("phone poll", {15'h0000, ok}, 16'h0001);
    read_check("phone done", `ADDR_RAW_THREE, 16'h0003);
    host.write_reg(`ADDR_PHONE_CTRL, 16'h0000);
    read_check("phone off", `ADDR_RAW_THREE, 16'h0000);
    @(posedge mclk);
    src <= 19'h00004;
    repeat (4) @(posedge mclk);
    src <= 19'h00000;
    repeat (4) @(posedge mclk);
    read_check("fault held", `ADDR_RAW_THREE, 16'h1000);
    read_check("fault cleared", `ADDR_RAW_THREE, 16'h0000);
    host.write_reg(16'h0200, 16'hFFFF);
    read_check("unmapped write", `ADDR_RAW_THREE, 16'h1000);
    read_check("unmapped read", 16'h0200, 16'h0000);
    host.write_reg(`ADDR_RAW_THREE, 16'hFFFF);
    read_check("read-only word", `ADDR_RAW_THREE, 16'h0000);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check("second reset", {13'h0000, sysEna, asyncEna, bootDone}, 16'h0000);
    boot_up();
    host.poll_bit(`ADDR_RAW_FOUR, `B4_BOOT, ok);
    check("reboot done", {15'h0000, ok}, 16'h0001);
    finishTest();
  end
endmodule : test_interrupt_raw_status_flags
